// file: bpoc_defines.vh
// constants for the port option control block: register offset,
// field positions, reset values and pci command codes.
// assumes an apb slave at 32-bit word granularity on ref_clk.
// Operation
// (R1) bit 3 set: secondary line/multiple read retry matches plain read.
// (R2) bit 4 set: secondary write-invalidate retry matches plain write.
// (R3) bit 5 set: primary read-line and read-multiple retries interchange.
// (R4) bit 6 set: secondary read-line and read-multiple retries interchange.
// (R5) bit 7 clear: primary write-invalidate forwarded as plain write.
// (R6) bit 8 clear: secondary write-invalidate forwarded as plain write.
// (R7) bit 9 set: long requests used for locked cycles.
// (R8) bit 10 set: secondary master holds request until fifo empty or stop.
// (R9) bit 11 set: primary master holds request until fifo empty or stop.
// (R10) bits 15:12 reserved, read zero, reset zero.
// (R11) option changes apply only to transactions started after the write.
`ifndef BPOC_DEFINES_VH
`define BPOC_DEFINES_VH
`define BPOC_OFS_PORT_OPT     12'h074
`define BPOC_OFS_STATUS       12'h078
`define BPOC_PORT_OPT_RESET   16'h0C6A
`define BPOC_PORT_OPT_WMASK   16'h0FFE
`define BPOC_BIT_P_RD_ALIAS   1
`define BPOC_BIT_P_WR_ALIAS   2
`define BPOC_BIT_S_RD_ALIAS   3
`define BPOC_BIT_S_WR_ALIAS   4
`define BPOC_BIT_P_RLM_ALIAS  5
`define BPOC_BIT_S_RLM_ALIAS  6
`define BPOC_BIT_P_MWI_KEEP   7
`define BPOC_BIT_S_MWI_KEEP   8
`define BPOC_BIT_LONG_LOCK    9
`define BPOC_BIT_S_HOLD_REQ   10
`define BPOC_BIT_P_HOLD_REQ   11
`define BPOC_CMD_MEM_READ     4'h6
`define BPOC_CMD_MEM_WRITE    4'h7
`define BPOC_CMD_MEM_READ_MUL 4'hC
`define BPOC_CMD_MEM_READ_LN  4'hE
`define BPOC_CMD_MEM_WRITE_INV 4'hF
`endif

// file: bpoc_port.v
// one side of the bridge: retry match, command conversion and request hold.
// the options come in already latched at transaction start by the top.
`include "bpoc_defines.vh"
module bpoc_port (
  input  wire       ref_clk,       // pci clock
  input  wire       rst_n,         // sync reset, active low
  input  wire       rd_alias,      // plain read alias enable
  input  wire       wr_alias,      // plain write alias enable
  input  wire       rlm_alias,     // line/multiple alias enable
  input  wire       mwi_keep,      // forward write-invalidate unconverted
  input  wire       hold_req,      // hold request option
  input  wire       long_lock,     // long request for locked cycles
  input  wire [3:0] retry_cmd,     // command of retried cycle
  input  wire [3:0] pend_cmd,      // command of pending delayed transaction
  input  wire [3:0] fwd_in_cmd,    // command accepted for forwarding
  input  wire       req_want,      // master has a transaction to run
  input  wire       frame_seen,    // master asserted frame
  input  wire       fifo_empty,    // no pending transactions in fifo
  input  wire       tgt_term,      // target terminated the transfer
  input  wire       lock_cycle,    // current cycle is locked
  output reg        match_r,       // retry matches pending
  output reg  [3:0] fwd_out_cmd_r, // command to issue on destination
  output reg        req_r          // master request, active high
);
  reg       match_nxt;
  reg       granted_r;
  wire      is_line_mul_r = (retry_cmd == `BPOC_CMD_MEM_READ_LN) ||
                            (retry_cmd == `BPOC_CMD_MEM_READ_MUL);
  wire      is_line_mul_p = (pend_cmd == `BPOC_CMD_MEM_READ_LN) ||
                            (pend_cmd == `BPOC_CMD_MEM_READ_MUL);
  always @* begin
    match_nxt = (retry_cmd == pend_cmd);
    if (rd_alias && is_line_mul_r && pend_cmd == `BPOC_CMD_MEM_READ)
      match_nxt = 1'b1;                                      // [R1]
    if (wr_alias && retry_cmd == `BPOC_CMD_MEM_WRITE_INV &&
        pend_cmd == `BPOC_CMD_MEM_WRITE)
      match_nxt = 1'b1;                                      // [R2]
    if (rlm_alias && is_line_mul_r && is_line_mul_p)
      match_nxt = 1'b1;                                      // [R3] [R4]
  end
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      match_r       <= 1'b0;
      fwd_out_cmd_r <= 4'h0;
      req_r         <= 1'b0;
      granted_r     <= 1'b0;
    end else begin
      match_r <= match_nxt;
      if (!mwi_keep && fwd_in_cmd == `BPOC_CMD_MEM_WRITE_INV)
        fwd_out_cmd_r <= `BPOC_CMD_MEM_WRITE;                // [R5] [R6]
      else
        fwd_out_cmd_r <= fwd_in_cmd;
      // once frame is out, drop the request unless holding is enabled or a locked cycle has long_lock set
      if (frame_seen)
        granted_r <= 1'b1;
      if (!req_want || tgt_term)
        granted_r <= 1'b0;
      if (!req_want)
        req_r <= 1'b0;
      else if (lock_cycle && long_lock)
        req_r <= 1'b1;                                       // [R7]
      else if (hold_req)
        req_r <= !(fifo_empty || tgt_term);                  // [R8] [R9]
      else
        req_r <= !(frame_seen || granted_r);
    end
  end
endmodule // bpoc_port

// file: bpoc_top.v
// port option register behind an apb slave, with the two port engines.
// assumes apb signals synchronous to ref_clk; one wait state per access.
//
// Local design decisions: the register offsets and register access over APB.
`include "bpoc_defines.vh"
module bpoc_top (
  input  wire        ref_clk,        // pci clock, 100 mhz
  input  wire        rst_n,          // sync reset, active low
  input  wire        psel,           // apb select
  input  wire        penable,        // apb enable
  input  wire        pwrite,         // apb direction
  input  wire [11:0] paddr,          // apb byte address
  input  wire [31:0] pwdata,         // apb write data
  output reg  [31:0] prdata,         // apb read data
  output reg         pready,         // apb ready
  output reg         pslverr,        // apb error
  input  wire        p_start,        // primary transaction start/retry
  input  wire [3:0]  p_retry_cmd,    // primary retry command
  input  wire [3:0]  p_pend_cmd,     // primary pending command
  input  wire [3:0]  p_fwd_cmd,      // primary-accepted command
  input  wire        p_req_want,     // primary master wants bus
  input  wire        p_frame,        // primary master frame asserted
  input  wire        p_fifo_empty,   // primary master fifo empty
  input  wire        p_tgt_term,     // primary target termination
  input  wire        p_lock,         // primary locked cycle
  input  wire        s_start,        // secondary transaction start/retry
  input  wire [3:0]  s_retry_cmd,    // secondary retry command
  input  wire [3:0]  s_pend_cmd,     // secondary pending command
  input  wire [3:0]  s_fwd_cmd,      // secondary-accepted command
  input  wire        s_req_want,     // secondary master wants bus
  input  wire        s_frame,        // secondary master frame asserted
  input  wire        s_fifo_empty,   // secondary master fifo empty
  input  wire        s_tgt_term,     // secondary target termination
  input  wire        s_lock,         // secondary locked cycle
  output wire        p_match,        // primary retry match
  output wire [3:0]  p_dest_cmd,     // command issued on secondary bus
  output wire        p_req,          // primary master request
  output wire        s_match,        // secondary retry match
  output wire [3:0]  s_dest_cmd,     // command issued on primary bus
  output wire        s_req           // secondary master request
);
  reg  [15:0] port_opt_r;
  reg  [15:0] p_opt_r;
  reg  [15:0] s_opt_r;
  wire        acc = psel && penable && !pready;
  // writes land on the edge where the master sees pready high
  wire        fin = psel && penable && pready;
  wire        hit_opt = (paddr == `BPOC_OFS_PORT_OPT);
  wire        hit_st  = (paddr == `BPOC_OFS_STATUS);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      port_opt_r <= `BPOC_PORT_OPT_RESET;
      p_opt_r    <= `BPOC_PORT_OPT_RESET;
      s_opt_r    <= `BPOC_PORT_OPT_RESET;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      pready  <= acc;
      pslverr <= acc && !hit_opt && !hit_st;
      prdata  <= 32'h0000_0000;
      if (fin && pwrite && hit_opt)
        port_opt_r <= pwdata[15:0] & `BPOC_PORT_OPT_WMASK;  // [R10]
      if (acc && !pwrite && hit_opt)
        prdata <= {16'h0000, port_opt_r};                    // [R10]
      if (acc && !pwrite && hit_st)
        prdata <= {16'h0000, p_opt_r[11:0] ^ s_opt_r[11:0],
                   2'b00, s_req, p_req};
      // options latch at each start so running transfers keep theirs
      if (p_start)
        p_opt_r <= port_opt_r;                               // [R11]
      if (s_start)
        s_opt_r <= port_opt_r;                               // [R11]
    end
  end

  bpoc_port u_pri (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .rd_alias      (p_opt_r[`BPOC_BIT_P_RD_ALIAS]),
    .wr_alias      (p_opt_r[`BPOC_BIT_P_WR_ALIAS]),
    .rlm_alias     (p_opt_r[`BPOC_BIT_P_RLM_ALIAS]),    // [R3]
    .mwi_keep      (p_opt_r[`BPOC_BIT_P_MWI_KEEP]),     // [R5]
    .hold_req      (p_opt_r[`BPOC_BIT_P_HOLD_REQ]),     // [R9]
    .long_lock     (p_opt_r[`BPOC_BIT_LONG_LOCK]),      // [R7]
    .retry_cmd     (p_retry_cmd),
    .pend_cmd      (p_pend_cmd),
    .fwd_in_cmd    (p_fwd_cmd),
    .req_want      (p_req_want),
    .frame_seen    (p_frame),
    .fifo_empty    (p_fifo_empty),
    .tgt_term      (p_tgt_term),
    .lock_cycle    (p_lock),
    .match_r       (p_match),
    .fwd_out_cmd_r (p_dest_cmd),
    .req_r         (p_req)
  );

  bpoc_port u_sec (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .rd_alias      (s_opt_r[`BPOC_BIT_S_RD_ALIAS]),     // [R1]
    .wr_alias      (s_opt_r[`BPOC_BIT_S_WR_ALIAS]),     // [R2]
    .rlm_alias     (s_opt_r[`BPOC_BIT_S_RLM_ALIAS]),    // [R4]
    .mwi_keep      (s_opt_r[`BPOC_BIT_S_MWI_KEEP]),     // [R6]
    .hold_req      (s_opt_r[`BPOC_BIT_S_HOLD_REQ]),     // [R8]
    .long_lock     (s_opt_r[`BPOC_BIT_LONG_LOCK]),      // [R7]
    .retry_cmd     (s_retry_cmd),
    .pend_cmd      (s_pend_cmd),
    .fwd_in_cmd    (s_fwd_cmd),
    .req_want      (s_req_want),
    .frame_seen    (s_frame),
    .fifo_empty    (s_fifo_empty),
    .tgt_term      (s_tgt_term),
    .lock_cycle    (s_lock),
    .match_r       (s_match),
    .fwd_out_cmd_r (s_dest_cmd),
    .req_r         (s_req)
  );
endmodule // bpoc_top

// file: bpoc_top_properties.sv
// checker: apb handshake and port engine relations of bpoc_top.
// assumes it is bound to bpoc_top and sees only its ports.
`include "bpoc_defines.vh"
module bpoc_props (
  input logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic [3:0]  p_retry_cmd, p_pend_cmd, p_fwd_cmd, p_dest_cmd,
  input logic [3:0]  s_fwd_cmd, s_dest_cmd,
  input logic        p_match, p_req_want, p_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_err: assert property (pready |-> pslverr ==
    !(paddr == `BPOC_OFS_PORT_OPT || paddr == `BPOC_OFS_STATUS))
    else $error("error flag wrong for address");
  a_rsvd_zero: assert property (pready && !pwrite &&
    paddr == `BPOC_OFS_PORT_OPT |-> prdata[15:12] == 4'h0 && !prdata[0])
    else $error("reserved bits read nonzero");
  a_exact_match: assert property ($past(rst_n) &&
    $past(p_retry_cmd) == $past(p_pend_cmd) |-> p_match)
    else $error("exact command did not match");
  a_dest_pass: assert property ($past(rst_n) &&
    $past(p_fwd_cmd) != 4'hF |-> p_dest_cmd == $past(p_fwd_cmd))
    else $error("forwarded command altered");
  a_mwi_dest: assert property ($past(rst_n) &&
    $past(s_fwd_cmd) == 4'hF |-> s_dest_cmd inside {4'h7, 4'hF})
    else $error("write invalidate forwarded wrongly");
  a_req_drop: assert property ($past(rst_n) &&
    !$past(p_req_want) |-> !p_req)
    else $error("request without work");
endmodule // bpoc_props
bind bpoc_top bpoc_props i_bpoc_props (.ref_clk, .rst_n, .psel, .penable,
  .pwrite, .pready, .pslverr, .paddr, .prdata, .p_retry_cmd, .p_pend_cmd,
  .p_fwd_cmd, .p_dest_cmd, .s_fwd_cmd, .s_dest_cmd, .p_match, .p_req_want,
  .p_req);

// file: bpoc_pci_model.sv
// partner: pci arbiter and target facing one internal master.
// grants two cycles after request, bursts 8 cycles, then fifo drains.
module bpoc_pci_model (
  input  logic ref_clk,    // pci clock
  input  logic rst_n,      // sync reset, active low
  input  logic req,        // master request
  output logic frame,      // master frame seen
  output logic fifo_empty  // fifo drained
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  always @(posedge ref_clk)
    if (!rst_n)
      cnt_r <= 4'h0;
    else if (req || cnt_r != 4'h0)
      cnt_r <= cnt_r + 4'h1;
  assign frame      = cnt_r >= 4'h2 && cnt_r <= 4'h9;
  assign fifo_empty = cnt_r >= 4'hA;
endmodule // bpoc_pci_model

// file: bpoc_top_tb.sv
// testbench: register access, retry matching, conversion, request hold.
// assumes bpoc_top with pci partner models on both master sides.
`include "bpoc_defines.vh"
module bpoc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, se;
  logic        p_start, s_start, p_want, s_want, p_lock, s_lock, p_fe, s_fe;
  logic        p_frame, s_frame, p_match, s_match, p_req, s_req, p_tt, s_tt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [3:0]  p_rc, p_pc, p_fc, s_rc, s_pc, s_fc, p_dc, s_dc;
  logic [15:0] opt, lat;
  logic [3:0]  cmds [5] = '{4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
  int          err_total, check_count, k, n;
  bpoc_top i_bpoc_top (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .p_start, .p_retry_cmd(p_rc),
    .p_pend_cmd(p_pc), .p_fwd_cmd(p_fc), .p_req_want(p_want), .p_frame,
    .p_fifo_empty(p_fe), .p_tgt_term(p_tt), .p_lock, .s_start,
    .s_retry_cmd(s_rc), .s_pend_cmd(s_pc), .s_fwd_cmd(s_fc), .s_lock,
    .s_req_want(s_want), .s_frame, .s_fifo_empty(s_fe), .s_tgt_term(s_tt),
    .p_match, .p_dest_cmd(p_dc), .p_req, .s_match, .s_dest_cmd(s_dc), .s_req);
  bpoc_pci_model i_bpoc_pci_model (.ref_clk, .rst_n, .req(p_req),
    .frame(p_frame), .fifo_empty(p_fe));
  bpoc_pci_model i_bpoc_pci_model_s (.ref_clk, .rst_n, .req(s_req),
    .frame(s_frame), .fifo_empty(s_fe));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic em(logic [3:0] r, q, logic ard, awr, alm);
    return r == q || ard && (r == 4'hE || r == 4'hC) && q == 4'h6 ||
      awr && r == 4'hF && q == 4'h7 || alm && {r, q} inside {8'hCE, 8'hEC};
  endfunction
  function automatic logic [3:0] ed(logic [3:0] f, logic keep);
    return (f == 4'hF && !keep) ? 4'h7 : f;
  endfunction
  task automatic chk(logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic go();
    @(posedge ref_clk);
    {p_start, s_start} <= 2'b11;
    lat = opt & `BPOC_PORT_OPT_WMASK;
    @(posedge ref_clk);
    {p_start, s_start} <= 2'b00;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    {psel, penable, pwrite, p_start, s_start, p_want, s_want, rst_n} = '0;
    {p_lock, s_lock, paddr, pwdata, p_rc, p_pc, p_fc, s_rc, s_pc, s_fc} = '0;
    {p_tt, s_tt} = 2'b00;
    seed = 78061;
    lat = `BPOC_PORT_OPT_RESET;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'b0, `BPOC_OFS_PORT_OPT, 32'h0);
    chk(rd, 32'h0C6A);
    // both sides hold the reset options and no master requests yet
    bus(1'b0, `BPOC_OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `BPOC_OFS_PORT_OPT, 32'hFFFFFFFF);
    bus(1'b0, `BPOC_OFS_PORT_OPT, 32'h0);
    chk(rd, 32'h0FFE);
    bus(1'b0, 12'h100, 32'h0);
    chk(se, 32'h1);
    $display("test registers done");
    for (k = 0; k < 200; k++) begin
      opt = xs();
      bus(1'b1, `BPOC_OFS_PORT_OPT, {16'h0, opt});
      if (opt[15]) go();
      @(posedge ref_clk);
      {p_rc, p_pc, p_fc} <= {cmds[xs() % 5], cmds[xs() % 5], cmds[xs() % 5]};
      {s_rc, s_pc, s_fc} <= {cmds[xs() % 5], cmds[xs() % 5], cmds[xs() % 5]};
      repeat (2) @(posedge ref_clk);
      chk(p_match, em(p_rc, p_pc, lat[1], lat[2], lat[5]));
      chk(s_match, em(s_rc, s_pc, lat[3], lat[4], lat[6]));
      chk(p_dc, ed(p_fc, lat[7]));
      chk(s_dc, ed(s_fc, lat[8]));
    end
    $display("test matching done");
    for (k = 0; k < 4; k++) begin
      opt = {4'h0, {2{k[0]}}, k == 2, 9'h06A};
      bus(1'b1, `BPOC_OFS_PORT_OPT, {16'h0, opt});
      go();
      {p_want, s_want, p_lock, s_lock} <= {2'b11, {2{k >= 2}}};
      n = 0;
      while (p_frame !== 1'b1 && n++ < 20) @(posedge ref_clk);
      chk(p_frame, 32'h1);
      repeat (3) @(posedge ref_clk);
      chk(p_req, k != 0);
      chk(s_req, k != 0);
      if (k == 3) begin
        // locked but no long request: target stop ends the held request
        {p_tt, s_tt} <= 2'b11;
        @(posedge ref_clk);
        {p_tt, s_tt} <= 2'b00;
        @(posedge ref_clk);
        chk(p_req, 32'h0);
        chk(s_req, 32'h0);
      end
      {p_want, s_want, p_lock, s_lock} <= 4'h0;
      repeat (20) @(posedge ref_clk);
    end
    $display("test request hold done");
    tally_and_finish();
  end
endmodule // bpoc_top_tb
